//--- design/reset_guard_and_flag_logic.sv
// Reset supervision: guarded pin-function, threshold and watchdog codes, low-voltage qualification,
// sticky cause flags, key reset, watchdog time-out handling, AXI4-Lite registers and interrupt.
// Assumes one 20 MHz clock; low-voltage and reset pins are asynchronous, mode and time-out are same-clock.
//
// The AXI4-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "reset_guard_cfg.svh"

module reset_guard_and_flag_logic
    import reset_guard_pkg::*;
#(
    parameter int SRESET_CYCLES = `SRESET_CYCLES,
    parameter int RESET_PULSE_CYCLES = `RESET_PULSE_CYCLES,
    parameter int SLOW_OSC_DIV = `SLOW_OSC_DIV
)
(
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    input wire axi_req_s i_axi,
    output axi_rsp_s o_axi,
    input wire logic i_lv_detect,
    input wire logic i_ext_reset_pin,
    input wire logic i_sleep_mode,
    input wire logic i_wdt_timeout,
    output logic o_sys_reset,
    output logic o_pc_sp_clear,
    output logic o_pin_is_reset,
    output logic o_wdt_enable,
    output logic o_lv_supervise_en,
    output logic o_irq
);
    // Bus side flops
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic aw_held, w_held;
    logic [`AXI_ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic w_lane0;
    logic [32:0] rd_word, wr_word; // Read mux result, unmapped flag on top
    logic aw_hs, w_hs, ar_hs, wr_fire;
    logic next_aw_held, next_w_held, next_bvalid, next_rvalid;
    // Registers
    logic [7:0] reset_pin_function;
    logic [3:0] reset_cause_flags;
    logic [7:0] low_voltage_threshold;
    logic [1:0] qualify_time_select;
    logic [4:0] watchdog_enable_code;
    logic timeout_status_flag;
    logic [`IRQ_W-1:0] irq_status, irq_mask, irq_event, next_irq_status;
    logic [3:0] flag_set, flag_keep;
    // Sequencer
    rst_state_e state;
    logic [15:0] seq_cnt;
    logic [2:0] pend;
    logic [2:0] bad_vec;
    logic pin_bad, thr_valid, thr_bad, wdt_bad;
    logic imm_cold, warm, acc, delay_done, restore_pin, enter_pulse, key_hit;
    // Low-voltage path
    logic [15:0] div_cnt;
    logic osc_tick;
    logic lv_meta, lv_sync, lv_active, lv_fire;
    logic [7:0] lv_cnt, qual_ticks;
    logic ext_meta, ext_sync, ext_prev, ext_fall;
    logic we_pin, we_flags, we_thr, we_qual, we_wdt, we_istat, we_imask, wr_mapped;

    assign o_axi = '{awready: awready, wready: wready, bvalid: bvalid, bresp: bresp,
                     arready: arready, rvalid: rvalid, rdata: rdata, rresp: rresp};

    // Handshake terms; one write and one read in flight at most
    always_comb
    begin
        aw_hs = i_axi.awvalid & awready;
        w_hs = i_axi.wvalid & wready;
        ar_hs = i_axi.arvalid & arready;
        wr_fire = aw_held & w_held & ~bvalid;
        next_aw_held = (aw_held | aw_hs) & ~wr_fire;
        next_w_held = (w_held | w_hs) & ~wr_fire;
        next_bvalid = wr_fire | (bvalid & ~i_axi.bready);
        next_rvalid = ar_hs | (rvalid & ~i_axi.rready);
    end

    // Read mux; unimplemented bits read zero
    function automatic logic [32:0] read_word(input logic [`AXI_ADDR_W-1:0] a);
        logic [32:0] r;
        r = 33'h000000000;
        case (a)
            `OFF_PIN_FUNCTION: r[7:0] = reset_pin_function;
            `OFF_CAUSE_FLAGS: r[3:0] = reset_cause_flags;
            `OFF_THRESHOLD: r[7:0] = low_voltage_threshold;
            `OFF_QUALIFY_TIME: r[1:0] = qualify_time_select;
            `OFF_PROG_CTRL: r[7:0] = 8'h00;
            `OFF_WDT_CTRL: r[7:0] = {timeout_status_flag, 2'h0, watchdog_enable_code};
            `OFF_IRQ_STATUS: r[`IRQ_W-1:0] = irq_status;
            `OFF_IRQ_MASK: r[`IRQ_W-1:0] = irq_mask;
            default: r[32] = 1'b1;
        endcase
        return r;
    endfunction

    // Write channel capture and response
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= `AXI_OKAY;
            aw_addr <= 8'h00;
            w_data <= 32'h00000000;
            w_lane0 <= 1'b0;
        end
        else
        begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            bvalid <= next_bvalid;
            awready <= ~next_aw_held & ~next_bvalid;
            wready <= ~next_w_held & ~next_bvalid;
            if (aw_hs)
                aw_addr <= i_axi.awaddr;
            if (w_hs)
            begin
                w_data <= i_axi.wdata;
                w_lane0 <= i_axi.wstrb[0];
            end
            if (wr_fire)
                bresp <= wr_mapped ? `AXI_OKAY : `AXI_SLVERR;
        end
    end

    // Read channel; no read side effects
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst)
        begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= `AXI_OKAY;
        end
        else
        begin
            rvalid <= next_rvalid;
            arready <= ~next_rvalid;
            if (ar_hs)
            begin
                rdata <= rd_word[31:0];
                rresp <= rd_word[32] ? `AXI_SLVERR : `AXI_OKAY;
            end
        end
    end

    // Write strobes; all fields live in byte lane 0
    always_comb
    begin
        rd_word = read_word(i_axi.araddr);
        wr_word = read_word(aw_addr);
        wr_mapped = ~wr_word[32];
        we_pin = wr_fire & w_lane0 & (aw_addr == `OFF_PIN_FUNCTION);
        we_flags = wr_fire & w_lane0 & (aw_addr == `OFF_CAUSE_FLAGS);
        we_thr = wr_fire & w_lane0 & (aw_addr == `OFF_THRESHOLD);
        we_qual = wr_fire & w_lane0 & (aw_addr == `OFF_QUALIFY_TIME);
        we_wdt = wr_fire & w_lane0 & (aw_addr == `OFF_WDT_CTRL);
        we_istat = wr_fire & w_lane0 & (aw_addr == `OFF_IRQ_STATUS);
        we_imask = wr_fire & w_lane0 & (aw_addr == `OFF_IRQ_MASK);
        key_hit = wr_fire & w_lane0 & (aw_addr == `OFF_PROG_CTRL) & (w_data[7:0] == `PROG_RESET_KEY);
    end

    // Guarded code checks
    always_comb
    begin
        pin_bad = (reset_pin_function != `PIN_FN_IO) && (reset_pin_function != `PIN_FN_RESET);
        thr_valid = (low_voltage_threshold == `THR_1V70) || (low_voltage_threshold == `THR_1V90) ||
                    (low_voltage_threshold == `THR_2V55) || (low_voltage_threshold == `THR_3V15) ||
                    (low_voltage_threshold == `THR_3V80);
        thr_bad = !thr_valid && (low_voltage_threshold != `THR_OFF);
        wdt_bad = (watchdog_enable_code != `WDT_CODE_ENABLE) && (watchdog_enable_code != `WDT_CODE_DISABLE);
        bad_vec = {wdt_bad, thr_bad, pin_bad};
    end

    // Reset requests; a pulse already in progress absorbs new ones
    always_comb
    begin
        acc = (state != ST_PULSE);
        imm_cold = key_hit | lv_fire | ext_fall;
        warm = i_wdt_timeout & ~i_sleep_mode;
        delay_done = (state == ST_DELAY) && (seq_cnt == 16'h0000) && !imm_cold && !warm;
        enter_pulse = (acc & (imm_cold | warm)) | delay_done;
        restore_pin = (acc & imm_cold) | delay_done;
    end

    // Sequencer: delayed software reset, then a fixed reset pulse
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst)
        begin
            state <= ST_IDLE;
            seq_cnt <= 16'h0000;
            pend <= 3'h0;
            o_sys_reset <= 1'b0;
        end
        else
        begin
            case (state)
                ST_IDLE:
                begin
                    if (enter_pulse)
                    begin
                        state <= ST_PULSE;
                        seq_cnt <= 16'(RESET_PULSE_CYCLES - 1);
                        o_sys_reset <= 1'b1;
                    end
                    else if (|bad_vec)
                    begin
                        state <= ST_DELAY;
                        seq_cnt <= 16'(SRESET_CYCLES - 1);
                        pend <= bad_vec;
                    end
                end
                ST_DELAY:
                begin
                    if (enter_pulse)
                    begin
                        state <= ST_PULSE;
                        seq_cnt <= 16'(RESET_PULSE_CYCLES - 1);
                        o_sys_reset <= 1'b1;
                        pend <= 3'h0;
                    end
                    else
                    begin
                        seq_cnt <= seq_cnt - 16'h0001;
                        pend <= pend | bad_vec;
                    end
                end
                ST_PULSE:
                begin
                    if (seq_cnt == 16'h0000)
                    begin
                        state <= ST_IDLE;
                        o_sys_reset <= 1'b0;
                    end
                    else
                        seq_cnt <= seq_cnt - 16'h0001;
                end
                default:
                begin
                    state <= ST_IDLE;
                    o_sys_reset <= 1'b0;
                end
            endcase
        end
    end

    // Pin function register and override output
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst)
        begin
            reset_pin_function <= `PIN_FN_IO;
            o_pin_is_reset <= 1'b0;
        end
        else
        begin
            if (restore_pin)
                reset_pin_function <= `PIN_FN_IO;
            else if (we_pin)
                reset_pin_function <= w_data[7:0];
            o_pin_is_reset <= (reset_pin_function == `PIN_FN_RESET);
        end
    end

    // Threshold and qualify select; a qualified low-voltage reset leaves both alone
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst)
        begin
            low_voltage_threshold <= `THR_1V70;
            qualify_time_select <= `QSEL_RESET;
        end
        else
        begin
            if (delay_done && pend[1])
                low_voltage_threshold <= `THR_1V70;
            else if (we_thr)
                low_voltage_threshold <= w_data[7:0];
            if (we_qual)
                qualify_time_select <= w_data[1:0];
        end
    end

    // Watchdog code and time-out flag; set wins over a clearing write
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst)
        begin
            watchdog_enable_code <= `WDT_CODE_ENABLE;
            timeout_status_flag <= 1'b0;
            o_wdt_enable <= 1'b0;
            o_pc_sp_clear <= 1'b0;
        end
        else
        begin
            if (restore_pin)
                watchdog_enable_code <= `WDT_CODE_ENABLE;
            else if (we_wdt)
                watchdog_enable_code <= w_data[4:0];
            if (i_wdt_timeout)
                timeout_status_flag <= 1'b1;
            else if (we_wdt && !w_data[`WDT_TIMEOUT_BIT])
                timeout_status_flag <= 1'b0;
            o_wdt_enable <= (watchdog_enable_code == `WDT_CODE_ENABLE);
            o_pc_sp_clear <= i_wdt_timeout & i_sleep_mode;
        end
    end

    // Cause flags: writing 0 clears, writing 1 keeps, hardware set wins
    always_comb
    begin
        flag_keep = we_flags ? w_data[3:0] : 4'hF;
        flag_set = 4'h0;
        flag_set[`CF_PIN_ERR] = delay_done & pend[0];
        flag_set[`CF_LV_RESET] = lv_fire & acc;
        flag_set[`CF_THR_ERR] = delay_done & pend[1];
        flag_set[`CF_WDT_ERR] = delay_done & pend[2];
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst)
            reset_cause_flags <= 4'h0;
        else
            reset_cause_flags <= (reset_cause_flags & flag_keep) | flag_set;
    end

    // Interrupt status, write one to clear, set wins
    always_comb
    begin
        irq_event = {key_hit & acc, i_wdt_timeout, flag_set[`CF_WDT_ERR], flag_set[`CF_LV_RESET],
                     flag_set[`CF_THR_ERR], flag_set[`CF_PIN_ERR]};
        next_irq_status = (irq_status & ~(we_istat ? w_data[`IRQ_W-1:0] : 6'h00)) | irq_event;
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst)
        begin
            irq_status <= 6'h00;
            irq_mask <= 6'h00;
            o_irq <= 1'b0;
        end
        else
        begin
            irq_status <= next_irq_status;
            if (we_imask)
                irq_mask <= w_data[`IRQ_W-1:0];
            o_irq <= |(next_irq_status & irq_mask);
        end
    end

    // Pin synchronisers; the first stage is never read, and ext_prev is a third stage for the falling-edge detect
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst)
        begin
            lv_meta <= 1'b0;
            lv_sync <= 1'b0;
            ext_meta <= 1'b1;
            ext_sync <= 1'b1;
            ext_prev <= 1'b1;
        end
        else
        begin
            lv_meta <= i_lv_detect;
            lv_sync <= lv_meta;
            ext_meta <= i_ext_reset_pin;
            ext_sync <= ext_meta;
            ext_prev <= ext_sync;
        end
    end
    assign ext_fall = o_pin_is_reset & ext_prev & ~ext_sync;

    // Oscillator tick divider; a tick stands for one low-speed period
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst)
        begin
            div_cnt <= 16'h0000;
            osc_tick <= 1'b0;
        end
        else
        begin
            osc_tick <= (div_cnt == 16'(SLOW_OSC_DIV - 1));
            div_cnt <= (div_cnt == 16'(SLOW_OSC_DIV - 1)) ? 16'h0000 : div_cnt + 16'h0001;
        end
    end

    // Qualification: the tick phase is random, so N ticks span N-1 to N periods
    always_comb
    begin
        case (qualify_time_select)
            2'h0: qual_ticks = `QUAL_TICKS_0;
            2'h1: qual_ticks = `QUAL_TICKS_1;
            2'h2: qual_ticks = `QUAL_TICKS_2;
            default: qual_ticks = `QUAL_TICKS_3;
        endcase
        lv_active = thr_valid & ~i_sleep_mode & lv_sync;
        lv_fire = lv_active & osc_tick & (lv_cnt == qual_ticks - 8'h01);
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst)
        begin
            lv_cnt <= 8'h00;
            o_lv_supervise_en <= 1'b0;
        end
        else
        begin
            if (!lv_active || lv_fire)
                lv_cnt <= 8'h00;
            else if (osc_tick)
                lv_cnt <= lv_cnt + 8'h01;
            o_lv_supervise_en <= thr_valid & ~i_sleep_mode;
        end
    end

    // Checks
    logic [15:0] dly_age;
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst || state != ST_DELAY)
            dly_age <= 16'h0000;
        else
            dly_age <= dly_age + 16'h0001;
    end

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);

    sequence s_delay_end;
        delay_done && pend[0];
    endsequence
    sequence s_pin_err_reset;
        o_sys_reset && reset_cause_flags[`CF_PIN_ERR] && reset_pin_function == `PIN_FN_IO;
    endsequence
    property p_pin_err_reset;
        s_delay_end |=> s_pin_err_reset;
    endproperty
    a_pin_err_reset: assert property (p_pin_err_reset) else $error("pin code error did not reset");
    property p_delay_len;
        delay_done |-> dly_age == 16'(SRESET_CYCLES - 1);
    endproperty
    a_delay_len: assert property (p_delay_len) else $error("software reset delay length wrong");
    property p_pin_select;
        $past(i_nrst) |-> o_pin_is_reset == ($past(reset_pin_function) == `PIN_FN_RESET);
    endproperty
    a_pin_select: assert property (p_pin_select) else $error("reset pin selection wrong");
    property p_flags_high_zero;
        (ar_hs && i_axi.araddr == `OFF_CAUSE_FLAGS) |=> rdata[31:4] == 28'h0000000;
    endproperty
    a_flags_high_zero: assert property (p_flags_high_zero) else $error("flag upper bits not zero");
    property p_sw_cannot_set;
        (we_flags && w_data[`CF_PIN_ERR] && !reset_cause_flags[`CF_PIN_ERR] && !flag_set[`CF_PIN_ERR])
            |=> !reset_cause_flags[`CF_PIN_ERR];
    endproperty
    a_sw_cannot_set: assert property (p_sw_cannot_set) else $error("software set the pin error flag");
    property p_sleep_no_lv;
        i_sleep_mode |=> lv_cnt == 8'h00 && !o_lv_supervise_en;
    endproperty
    a_sleep_no_lv: assert property (p_sleep_no_lv) else $error("supervision active in sleep");
    property p_thr_restore;
        (delay_done && pend[1]) |=> low_voltage_threshold == `THR_1V70 && reset_cause_flags[`CF_THR_ERR];
    endproperty
    a_thr_restore: assert property (p_thr_restore) else $error("threshold not restored");
    property p_lv_reset;
        (lv_fire && acc) |-> lv_cnt == qual_ticks - 8'h01 ##1
            (o_sys_reset && reset_cause_flags[`CF_LV_RESET] && $stable(low_voltage_threshold));
    endproperty
    a_lv_reset: assert property (p_lv_reset) else $error("low-voltage reset wrong");
    property p_key_reset;
        (key_hit && acc) |=> o_sys_reset [*2];
    endproperty
    a_key_reset: assert property (p_key_reset) else $error("key write did not reset");
    property p_wdt_sleep;
        (i_wdt_timeout && i_sleep_mode) |=> o_pc_sp_clear && timeout_status_flag;
    endproperty
    a_wdt_sleep: assert property (p_wdt_sleep) else $error("sleep time-out handling wrong");
    property p_wdt_code;
        $past(i_nrst) |-> o_wdt_enable == ($past(watchdog_enable_code) == `WDT_CODE_ENABLE);
    endproperty
    a_wdt_code: assert property (p_wdt_code) else $error("watchdog enable decode wrong");
endmodule // reset_guard_and_flag_logic

//--- design/reset_guard_cfg.svh
// Constants for the reset guard: register offsets, guarded codes, reset values, field positions, timing.
// Assumes inclusion by bare name from the package and the top module.
`ifndef RESET_GUARD_CFG_SVH
`define RESET_GUARD_CFG_SVH

// Clocking: system clock and nominal low-speed oscillator rate
`define SYS_CLK_HZ 20000000
`define SLOW_OSC_HZ 32000
`define SLOW_OSC_DIV (`SYS_CLK_HZ / `SLOW_OSC_HZ)
`define AXI_ADDR_W 8

// Register byte offsets
`define OFF_PIN_FUNCTION 8'h00
`define OFF_CAUSE_FLAGS 8'h04
`define OFF_THRESHOLD 8'h08
`define OFF_QUALIFY_TIME 8'h0C
`define OFF_PROG_CTRL 8'h10
`define OFF_WDT_CTRL 8'h14
`define OFF_IRQ_STATUS 8'h18
`define OFF_IRQ_MASK 8'h1C

// Reset pin function codes
`define PIN_FN_IO 8'h55
`define PIN_FN_RESET 8'hAA

// Threshold codes
`define THR_1V70 8'h66
`define THR_1V90 8'h55
`define THR_2V55 8'h33
`define THR_3V15 8'h99
`define THR_3V80 8'hAA
`define THR_OFF 8'hF0

// Qualification field reset value and length in oscillator ticks
`define QSEL_RESET 2'h1
`define QUAL_TICKS_0 8'h08
`define QUAL_TICKS_1 8'h20
`define QUAL_TICKS_2 8'h40
`define QUAL_TICKS_3 8'h80

// Watchdog enable codes and control register layout
`define WDT_CODE_ENABLE 5'h0A
`define WDT_CODE_DISABLE 5'h15
`define WDT_TIMEOUT_BIT 7

// Key that triggers a programming reset
`define PROG_RESET_KEY 8'h55

// Cause flag bits
`define CF_WDT_ERR 0
`define CF_THR_ERR 1
`define CF_LV_RESET 2
`define CF_PIN_ERR 3

// Interrupt status bits
`define IRQ_PIN_ERR 0
`define IRQ_THR_ERR 1
`define IRQ_LV_RESET 2
`define IRQ_WDT_ERR 3
`define IRQ_WDT_TIMEOUT 4
`define IRQ_KEY_RESET 5
`define IRQ_W 6

// Sequencer timing in system clock cycles
`define SRESET_CYCLES 16
`define RESET_PULSE_CYCLES 4

// AXI responses
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2

`endif

//--- design/reset_guard_pkg.sv
// Types for the reset guard: AXI4-Lite carriers and sequencer states.
// Assumes the constants header sits beside it on the include path.
`include "reset_guard_cfg.svh"
package reset_guard_pkg;
    typedef struct packed {
        logic awvalid;
        logic [`AXI_ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [`AXI_ADDR_W-1:0] araddr;
        logic rready;
    } axi_req_s;
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } axi_rsp_s;
    typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_PULSE} rst_state_e;
endpackage

//--- testbench/testbench.sv
// Self-checking bench for the reset guard: AXI4-Lite register tasks and one task per scenario.
// Assumes the design package and constants header are compiled first; short counts via parameters.
`timescale 1ns/1ps
module testbench;
import reset_guard_pkg::*;
logic i_clk_sys = 1'b0, i_nrst = 1'b0, lv = 1'b0, pin = 1'b1, slp = 1'b0, wto = 1'b0;
axi_req_s req = '0;
axi_rsp_s rsp;
logic sr, pcc, pir, wen, lsen, irq, pseen;
logic [7:0] d;
logic [1:0] r;
int n_mismatch = 0, compares = 0;
reset_guard_and_flag_logic #(.SRESET_CYCLES(4), .RESET_PULSE_CYCLES(2), .SLOW_OSC_DIV(4))
reset_guard_and_flag_logic_inst (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_axi(req), .o_axi(rsp),
    .i_lv_detect(lv), .i_ext_reset_pin(pin), .i_sleep_mode(slp), .i_wdt_timeout(wto), .o_sys_reset(sr),
    .o_pc_sp_clear(pcc), .o_pin_is_reset(pir), .o_wdt_enable(wen), .o_lv_supervise_en(lsen), .o_irq(irq));
// 20 MHz clock
initial forever #25 i_clk_sys = ~i_clk_sys;
task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e)
    begin
        n_mismatch++;
        $display("ERROR %s expected %h seen %h", n, e, g);
    end
endtask
// Leading edge keeps a strobe from being assigned twice in one step
task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_clk_sys);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= {24'h0, v};
    req.wstrb <= 4'hF;
    req.bready <= 1'b1;
    do
    begin
        @(posedge i_clk_sys);
        if (rsp.awready) req.awvalid <= 1'b0;
        if (rsp.wready) req.wvalid <= 1'b0;
    end while (!rsp.bvalid);
    req.bready <= 1'b0;
    r = rsp.bresp;
endtask
task rd(input logic [7:0] a);
    @(posedge i_clk_sys);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    do
    begin
        @(posedge i_clk_sys);
        if (rsp.arready) req.arvalid <= 1'b0;
    end while (!rsp.rvalid);
    req.rready <= 1'b0;
    d = rsp.rdata[7:0];
    r = rsp.rresp;
endtask
// Watch n cycles for a reset pulse; long enough that the pulse is over on return
task rstw(input logic e, input int n);
    logic s;
    s = 1'b0;
    pseen = 1'b0;
    repeat (n)
    begin
        @(posedge i_clk_sys);
        s = s | sr;
        pseen = pseen | pcc;
    end
    chk("sys_reset", {7'h0, e}, {7'h0, s});
endtask
task t_defaults;
    rd(8'h00); chk("pin_fn", 8'h55, d);
    rd(8'h08); chk("threshold", 8'h66, d);
    rd(8'h0C); chk("qualify", 8'h01, d);
    rd(8'h20); chk("rresp", 8'h02, {6'h0, r});
    wr(8'h20, 8'h01); chk("bresp", 8'h02, {6'h0, r});
    chk("wdt_en", 8'h01, {7'h0, wen});
    $display("test defaults done");
endtask
task t_pin;
    wr(8'h00, 8'hAA);
    @(posedge i_clk_sys);
    chk("pin_is_reset", 8'h01, {7'h0, pir});
    pin <= 1'b0;
    rstw(1'b1, 20);
    pin <= 1'b1;
    rd(8'h00); chk("pin_fn", 8'h55, d);
    wr(8'h00, 8'h12);
    rstw(1'b1, 40);
    rd(8'h04); chk("flags", 8'h08, d);
    rd(8'h00); chk("pin_fn", 8'h55, d);
    wr(8'h04, 8'hFF);
    rd(8'h04); chk("flags", 8'h08, d);
    wr(8'h04, 8'h00);
    rd(8'h04); chk("flags", 8'h00, d);
    wr(8'h04, 8'h08);
    rd(8'h04);
    chk("flags", 8'h00, d);
    $display("test pin done");
endtask
task t_lv;
    wr(8'h08, 8'h33);
    wr(8'h0C, 8'h00);
    lv <= 1'b1;
    repeat (10) @(posedge i_clk_sys);
    lv <= 1'b0;
    rstw(1'b0, 50);
    lv <= 1'b1;
    rstw(1'b1, 80);
    lv <= 1'b0;
    rd(8'h04); chk("flags", 8'h04, d);
    rd(8'h08); chk("threshold", 8'h33, d);
    // Qualify 01 needs 32 ticks: quiet for 100 cycles, then a reset
    wr(8'h0C, 8'h01);
    lv <= 1'b1;
    rstw(1'b0, 100);
    rstw(1'b1, 60);
    lv <= 1'b0;
    // Disable code stops supervision without a reset
    wr(8'h08, 8'hF0);
    @(posedge i_clk_sys);
    chk("lv_sup_en", 8'h00, {7'h0, lsen});
    lv <= 1'b1;
    rstw(1'b0, 50);
    lv <= 1'b0;
    wr(8'h08, 8'h12);
    rstw(1'b1, 40);
    rd(8'h04); chk("flags", 8'h06, d);
    rd(8'h08); chk("threshold", 8'h66, d);
    $display("test lv done");
endtask
task t_wdt;
    wr(8'h00, 8'hAA);
    slp <= 1'b1;
    @(posedge i_clk_sys);
    @(posedge i_clk_sys);
    chk("lv_sup_en", 8'h00, {7'h0, lsen});
    wto <= 1'b1;
    @(posedge i_clk_sys);
    wto <= 1'b0;
    rstw(1'b0, 10);
    chk("pc_sp_clear", 8'h01, {7'h0, pseen});
    slp <= 1'b0;
    wto <= 1'b1;
    @(posedge i_clk_sys);
    wto <= 1'b0;
    rstw(1'b1, 20);
    rd(8'h00); chk("pin_fn", 8'hAA, d);
    rd(8'h14); chk("timeout_flag", 8'h01, {7'h0, d[7]});
    wr(8'h14, 8'h15);
    @(posedge i_clk_sys);
    chk("wdt_en", 8'h00, {7'h0, wen});
    wr(8'h14, 8'h03);
    rstw(1'b1, 40);
    rd(8'h04); chk("flags", 8'h07, d);
    rd(8'h14); chk("wdt_code", 8'h0A, d & 8'h1F);
    $display("test wdt done");
endtask
task t_key;
    wr(8'h10, 8'h55);
    rstw(1'b1, 20);
    chk("irq", 8'h00, {7'h0, irq});
    wr(8'h1C, 8'h20);
    @(posedge i_clk_sys);
    chk("irq", 8'h01, {7'h0, irq});
    // Every event kind has fired by now
    rd(8'h18);
    chk("irq_status", 8'h3F, d);
    wr(8'h18, 8'hFF);
    @(posedge i_clk_sys);
    chk("irq", 8'h00, {7'h0, irq});
    rd(8'h18);
    chk("irq_status", 8'h00, d);
    $display("test key done");
endtask
task final_report;
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
endtask
initial
begin
    repeat (8) @(posedge i_clk_sys);
    i_nrst <= 1'b1;
    t_defaults;
    t_pin;
    t_lv;
    t_wdt;
    t_key;
    final_report;
end
// Whole run is under a thousand cycles
initial
begin
    #1000000;
    n_mismatch++;
    final_report;
end
endmodule // testbench
